// ### src/stw_device.sv
// tunable capacitor end: shift register on the link clock, word apply and wake timer
// Behaviour
// - master raises enable before any clock edge
// - sample data on every rising shift clock while enable is high
// - most significant bit sent first
// - master changes data on falling clock
// - enable falling edge applies shifted word
// - no bit count, keep last eight
// - respond only within own enable frame
// - common enable needs every device programmed
// - word: zeros, standby, five tuning bits
// - standby bit one means low current
// - tuning field unsigned zero to 31
// - shift clock at most 26 MHz
// - full performance 100 us after wake
`timescale 1ns/1ps
module stw_device #(
  parameter int WAKE_CYCLES = stw_pkg::WAKE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  stw_link_if.device link,
  output logic [stw_pkg::TUNE_W-1:0] tune_state_q,
  output logic standby_select_q,
  output logic word_applied_q,
  output logic perf_ready_q
);
  // refuse wake spans that the 24 bit wake counter cannot hold
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 16777215) begin
    $error("stw_device: WAKE_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  logic [stw_pkg::WORD_W-1:0] shift_q;

  // shifting is gated by enable, so the word is stable once enable drops even if scl still toggles
  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= stw_pkg::WORD_RESET;
    end else if (link.latch_enable) begin
      shift_q <= {shift_q[stw_pkg::WORD_W-2:0], link.sda};
    end
  end

  // ----------------------------------------------------------------
  // core clock domain
  // ----------------------------------------------------------------
  logic en_meta_q;
  logic en_sync_q;
  logic en_prev_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      en_meta_q <= link.latch_enable;
      en_sync_q <= en_meta_q;
      en_prev_q <= en_sync_q;
    end
  end

  logic apply;
  assign apply = en_prev_q && !en_sync_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tune_state_q <= '0;
      standby_select_q <= 1'b0;
    end else if (apply) begin
      tune_state_q <= shift_q[stw_pkg::TUNE_MSB_POS:stw_pkg::TUNE_LSB_POS];
      standby_select_q <= shift_q[stw_pkg::STANDBY_POS];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_applied_q <= 1'b0;
    end else begin
      word_applied_q <= apply;
    end
  end

  // ----------------------------------------------------------------
  // wake timer
  // ----------------------------------------------------------------
  logic [23:0] wake_cnt_q;
  logic waking;
  assign waking = apply && standby_select_q && !shift_q[stw_pkg::STANDBY_POS];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_cnt_q <= '0;
    end else if (waking) begin
      wake_cnt_q <= 24'(WAKE_CYCLES);
    end else if (wake_cnt_q != '0) begin
      wake_cnt_q <= wake_cnt_q - 24'h000001;
    end
  end

  // ready when active and no wake-up in progress
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      perf_ready_q <= 1'b1;
    end else if (apply) begin
      perf_ready_q <= !shift_q[stw_pkg::STANDBY_POS] && !waking && (wake_cnt_q <= 24'h000001);
    end else begin
      perf_ready_q <= !standby_select_q && (wake_cnt_q <= 24'h000001);
    end
  end
endmodule

// ### src/stw_link_if.sv
// three wire link between serial master and tunable capacitor
`timescale 1ns/1ps
interface stw_link_if;
  logic latch_enable;
  logic scl;
  logic sda;
  modport master (output latch_enable, output scl, output sda);
  modport device (input latch_enable, input scl, input sda);
endinterface

// ### src/stw_master.sv
// serial master end: frames a word on the three wire link from a user command
`timescale 1ns/1ps
module stw_master #(
  parameter int HALF_CYCLES = stw_pkg::SCL_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  stw_link_if.master link,
  input wire logic cmd_valid,
  input wire logic [stw_pkg::WORD_W-1:0] cmd_word,
  output logic cmd_ready_q
);
  // refuse half periods that break the shift clock limit or overflow the counter
  if (HALF_CYCLES < stw_pkg::SCL_HALF_CYC || HALF_CYCLES > 255) begin
    $error("stw_master: HALF_CYCLES too small or too large");
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD, ST_GAP
  } stw_state_e;

  stw_state_e state_q;
  logic [stw_pkg::CNT_W-1:0] cnt_q;
  logic [2:0] bits_q;
  logic [stw_pkg::WORD_W-1:0] word_q;
  logic en_q;
  logic scl_q;
  logic sda_q;

  assign link.latch_enable = en_q;
  assign link.scl = scl_q;
  assign link.sda = sda_q;

  localparam logic [stw_pkg::CNT_W-1:0] ESU_LOAD = stw_pkg::CNT_W'(stw_pkg::ESU_CYC - 1);
  localparam logic [stw_pkg::CNT_W-1:0] EHD_LOAD = stw_pkg::CNT_W'(stw_pkg::EHD_CYC - 1);
  localparam logic [stw_pkg::CNT_W-1:0] EOW_LOAD = stw_pkg::CNT_W'(stw_pkg::EOW_CYC - 1);
  localparam logic [stw_pkg::CNT_W-1:0] HALF_LOAD = stw_pkg::CNT_W'(HALF_CYCLES - 1);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      bits_q <= '0;
      word_q <= stw_pkg::WORD_RESET;
      en_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      cmd_ready_q <= 1'b1;
    end else begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 8'h01;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            // enable and first bit together, scl held low for the setup time
            en_q <= 1'b1;
            sda_q <= cmd_word[stw_pkg::WORD_W-1];
            word_q <= cmd_word;
            bits_q <= 3'h7;
            cnt_q <= ESU_LOAD;
            cmd_ready_q <= 1'b0;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP, ST_LOW: begin
          if (cnt_q == '0) begin
            scl_q <= 1'b1;
            cnt_q <= HALF_LOAD;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_q == '0) begin
            scl_q <= 1'b0;
            if (bits_q == '0) begin
              cnt_q <= EHD_LOAD;
              state_q <= ST_HOLD;
            end else begin
              // next bit only on the falling clock
              sda_q <= word_q[bits_q - 3'h1];
              bits_q <= bits_q - 3'h1;
              cnt_q <= HALF_LOAD;
              state_q <= ST_LOW;
            end
          end
        end
        ST_HOLD: begin
          if (cnt_q == '0) begin
            en_q <= 1'b0;
            cnt_q <= EOW_LOAD;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (cnt_q == '0) begin
            cmd_ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          en_q <= 1'b0;
          scl_q <= 1'b0;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ### src/stw_pkg.sv
// constants shared by both ends of the serial tuning word link
package stw_pkg;
  // ----------------------------------------------------------------
  // telegram layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam int TUNE_W = 5;
  localparam int TUNE_LSB_POS = 0;
  localparam int TUNE_MSB_POS = 4;
  localparam int STANDBY_POS = 5;
  localparam int ZERO_LO_POS = 6;
  localparam int ZERO_HI_POS = 7;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  localparam logic [TUNE_W-1:0] TUNE_MAX = 5'h1f;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 100;
  localparam int CORE_PERIOD_PS = 1000000 / CORE_CLK_MHZ;
  localparam int SCL_MAX_MHZ = 26;
  // least scl period in ps, rounded up
  localparam int SCL_MIN_PERIOD_PS = (1000000 + SCL_MAX_MHZ - 1) / SCL_MAX_MHZ;
  // least cycles per half period so that the full period is never too short
  localparam int SCL_HALF_CYC =
    (SCL_MIN_PERIOD_PS + 2 * CORE_PERIOD_PS - 1) / (2 * CORE_PERIOD_PS);
  localparam int ESU_PS = 19200;
  localparam int EHD_PS = 19200;
  localparam int EOW_PS = 38400;
  localparam int ESU_CYC = (ESU_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int EHD_CYC = (EHD_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int EOW_CYC = (EOW_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int WAKE_US = 100;
  localparam int WAKE_CYC = WAKE_US * CORE_CLK_MHZ;
  localparam int CNT_W = 8;
endpackage

// ### test/stw_link_properties.sv
// wire-level checks of the three wire link
`timescale 1ns/1ps
module stw_link_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic latch_enable,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] rise_cnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ---
  // shift clock rises seen within one frame
  // ---
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rise_cnt_q <= 4'h0;
    else if (!latch_enable) rise_cnt_q <= 4'h0;
    else if ($rose(scl)) rise_cnt_q <= rise_cnt_q + 4'h1;
  end
  scl_framed_a: assert property ($rose(scl) |-> latch_enable && $past(latch_enable))
    else $error("scl rose outside frame");
  scl_idle_a: assert property (!latch_enable |-> !scl)
    else $error("scl high while enable low");
  sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda))
    else $error("sda moved while scl high");
  sda_edge_a: assert property ($changed(sda) && latch_enable && $past(latch_enable) |-> $fell(scl))
    else $error("sda moved off falling scl");
  scl_high_a: assert property ($rose(scl) |-> scl[*2] ##1 !scl)
    else $error("scl high time wrong");
  enable_setup_a: assert property ($rose(latch_enable) |-> !scl[*2])
    else $error("scl too soon after enable");
  enable_hold_a: assert property ($fell(latch_enable) |-> !$past(scl) && !$past(scl, 2))
    else $error("enable fell too soon after scl");
  bit_count_a: assert property ($fell(latch_enable) |-> rise_cnt_q == 4'h8)
    else $error("frame not eight bits");
endmodule

// ### test/tb_top.sv
// testbench joining master and device ends over the link
`timescale 1ns/1ps
`define CHK(n, e, g) num_checks++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, g); end
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_word = 8'h00;
  logic cmd_ready_q, applied, perf, stby, applied2, stby2;
  logic [4:0] tune, tune2;
  logic [7:0] wire_sh = 8'h00;
  int wire_cnt, errors, num_checks;
  stw_link_if link();
  stw_link_if link2();
  stw_link_if link3();
  logic [7:0] common_word = 8'h00;
  logic applied3, stby3;
  logic [4:0] tune3;
  // third device shares enable and clock with the first, data line of its own
  assign link3.latch_enable = link.latch_enable;
  assign link3.scl = link.scl;
  stw_master stw_master_i (.core_clk, .reset_n, .link(link), .cmd_valid, .cmd_word, .cmd_ready_q);
  stw_device #(.WAKE_CYCLES(20)) stw_device_i (.core_clk, .reset_n, .link(link),
    .tune_state_q(tune), .standby_select_q(stby), .word_applied_q(applied), .perf_ready_q(perf));
  stw_device #(.WAKE_CYCLES(20)) stw_device_i2 (.core_clk, .reset_n, .link(link2),
    .tune_state_q(tune2), .standby_select_q(stby2), .word_applied_q(applied2), .perf_ready_q());
  stw_device #(.WAKE_CYCLES(20)) stw_device_i3 (.core_clk, .reset_n, .link(link3),
    .tune_state_q(tune3), .standby_select_q(stby3), .word_applied_q(applied3), .perf_ready_q());
  stw_link_properties stw_link_properties_i (.core_clk, .reset_n,
    .latch_enable(link.latch_enable), .scl(link.scl), .sda(link.sda));
  initial forever #5 core_clk = ~core_clk;
  // separate data line of the third device, first bit set at enable rise, later bits changed only on falling shift clock
  initial forever begin
    @(posedge link.latch_enable);
    link3.sda <= common_word[7];
    for (int k = 6; k >= 0; k--) begin
      @(negedge link.scl);
      link3.sda <= common_word[k];
    end
  end
  // ---
  // wire monitor rebuilds the word from the link
  // ---
  always @(posedge link.scl) if (link.latch_enable) begin
    wire_sh = {wire_sh[6:0], link.sda};
    wire_cnt++;
  end
  always @(posedge link.latch_enable) wire_cnt = 0;
  task automatic wait_applied(input bit second);
    int n;
    n = 0;
    while ((second ? applied2 : applied) !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("applied", 1'b1, second ? applied2 : applied)
  endtask
  task automatic send(input logic [7:0] w, input logic p);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    @(negedge core_clk);
    while (cmd_ready_q !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    `CHK("ready busy", 1'b0, cmd_ready_q)
    wait_applied(1'b0);
    `CHK("common apply", 1'b1, applied3)
    `CHK("wire word", w, wire_sh)
    `CHK("wire bits", 8, wire_cnt)
    `CHK("tune", w[4:0], tune)
    `CHK("standby", w[5], stby)
    `CHK("perf", p, perf)
  endtask
  // bench-driven frame on the second link, nb bits msb first
  task automatic raw(input logic [9:0] v, input int nb, input logic en);
    @(posedge core_clk);
    link2.latch_enable <= en;
    repeat (2) @(posedge core_clk);
    for (int i = nb - 1; i >= 0; i--) begin
      link2.sda <= v[i];
      repeat (2) @(posedge core_clk);
      link2.scl <= 1'b1;
      repeat (2) @(posedge core_clk);
      link2.scl <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    link2.latch_enable <= 1'b0;
    link2.sda <= ~link2.sda;
  endtask
  task automatic t_states;
    for (int v = 0; v < 32; v++) send({3'b000, v[4:0]}, 1'b1);
    $display("test states done");
  endtask
  task automatic t_wake;
    int n;
    send(8'h2a, 1'b0);
    send(8'h11, 1'b0);
    n = 0;
    while (perf !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("wake span", 1'b1, n >= 17 && n <= 23)
    $display("test wake done");
  endtask
  task automatic t_sideband;
    raw(10'h3a9, 10, 1'b1);
    wait_applied(1'b1);
    `CHK("last eight tune", 5'h09, tune2)
    `CHK("last eight stby", 1'b1, stby2)
    raw(10'h155, 8, 1'b0);
    repeat (6) @(posedge core_clk);
    raw(10'h000, 0, 1'b1);
    wait_applied(1'b1);
    `CHK("gated tune", 5'h09, tune2)
    `CHK("own enable", 5'h11, tune)
    $display("test sideband done");
  endtask
  task automatic t_common;
    common_word <= 8'h3c;
    send(8'h05, 1'b1);
    `CHK("common tune", 5'h1c, tune3)
    `CHK("common stby", 1'b1, stby3)
    `CHK("common peer", 5'h05, tune)
    $display("test common done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    link2.latch_enable <= 1'b0;
    link2.scl <= 1'b0;
    link2.sda <= 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    t_states;
    t_wake;
    t_sideband;
    t_common;
    complete_run;
  end
  initial begin
    #60us;
    errors++;
    complete_run;
  end
endmodule
